// [design/adc_ctrl_pkg.sv]
package adc_ctrl_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] OFFSET_CONTROL_0   = 3'h0;
  localparam logic [2:0] OFFSET_CONTROL_1   = 3'h1;
  localparam logic [2:0] OFFSET_TRIGGER     = 3'h2;
  localparam logic [2:0] OFFSET_RESULT_HIGH = 3'h3;
  localparam logic [2:0] OFFSET_RESULT_LOW  = 3'h4;
  localparam logic [2:0] OFFSET_STATUS      = 3'h5;

  // conversion_control_0 fields
  localparam int CHANNEL_LSB = 2;
  localparam int GO_BIT      = 1;
  localparam int ENABLE_BIT  = 0;

  // conversion_control_1 fields
  localparam int FORMAT_BIT    = 7;
  localparam int CLOCK_SEL_LSB = 4;
  localparam int NEG_REF_BIT   = 2;
  localparam int POS_REF_LSB   = 0;

  // status fields
  localparam int COMPLETION_BIT = 0;

  // Reset values
  localparam logic [7:0] CONTROL_0_RESET = 8'h00;
  localparam logic [7:0] CONTROL_1_RESET = 8'h00;
  localparam logic [7:0] TRIGGER_RESET   = 8'h00;
  localparam logic [7:0] RESULT_RESET    = 8'h00;

  // Conversion clock selections
  localparam logic [2:0] CLOCK_DIV2  = 3'h0;
  localparam logic [2:0] CLOCK_DIV8  = 3'h1;
  localparam logic [2:0] CLOCK_DIV32 = 3'h2;
  localparam logic [2:0] CLOCK_DIV4  = 3'h4;
  localparam logic [2:0] CLOCK_DIV16 = 3'h5;
  localparam logic [2:0] CLOCK_DIV64 = 3'h6;

  localparam logic [5:0] TRIGGER_OFF = 6'h00;
  localparam int RESULT_BITS = 10;

endpackage

// [design/sar_if.sv]
`timescale 1ns/1ns
interface sar_if;
  logic       tick;
  logic       start;
  logic       abort;
  logic       busy;
  logic       done;
  logic       sample;
  logic [9:0] dac;
  logic [9:0] result;

  modport ctrl (output tick, start, abort, input busy, done, sample, dac, result);
  modport core (input tick, start, abort, output busy, done, sample, dac, result);
endinterface

// [design/trigger_edge.sv]
`timescale 1ns/1ns
module trigger_edge #(
  parameter int SOURCES = 64
) (
  // Clock and reset
  input  wire logic               i_clock,
  input  wire logic               i_sys_rst,
  // Sources and selection
  input  wire logic [SOURCES-1:0] i_sources,
  input  wire logic [5:0]         i_select,
  // One-cycle rising-edge pulse
  output logic                    o_edge
);
  import adc_ctrl_pkg::*;

  typedef struct packed {
    logic prev;
    logic edge_seen;
  } state_t;

  state_t state;
  state_t next_state;
  logic   level;

  always_comb begin
    level = i_sources[i_select];
    next_state.prev = level;
    // Code zero switches the trigger off; all others are rising-edge sources
    next_state.edge_seen = (i_select != TRIGGER_OFF) && level && !state.prev; // [R18] [R4]
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_edge = state.edge_seen;
endmodule

// [design/sar_sequencer.sv]
`timescale 1ns/1ns
module sar_sequencer (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  // Comparator decision: input above trial code
  input  wire logic i_comp_high,
  // Control side
  sar_if.core       bus
);
  import adc_ctrl_pkg::*;

  typedef enum logic [1:0] {IDLE, ACQUIRE, CONVERT} phase_t;

  typedef struct packed {
    phase_t     phase;
    logic [3:0] idx;
    logic [9:0] code;
    logic       done;
    logic [9:0] result;
  } state_t;

  state_t state;
  state_t next_state;

  // Undecided bits copy the last decided bit; nothing decided gives zero
  function automatic logic [9:0] fill_partial(input logic [9:0] code, input logic [3:0] idx);
    logic [9:0] res;
    logic       last;
    res  = code;
    last = (idx < 4'h9) ? code[idx + 4'h1] : 1'b0;
    for (int b = 0; b < RESULT_BITS; b++) begin
      if (b <= int'(idx)) begin
        res[b] = last;
      end
    end
    return res;
  endfunction

  always_comb begin
    logic [9:0] c;
    c = state.code;
    next_state = state;
    next_state.done = 1'b0;
    case (state.phase)
      IDLE: begin
        if (bus.start) begin
          next_state.phase = ACQUIRE;
          next_state.code  = '0;
        end
      end
      ACQUIRE: begin
        if (bus.abort) begin
          next_state.phase  = IDLE;
          next_state.result = '0; // [R19]
          next_state.done   = 1'b1;
        end else if (bus.tick) begin
          next_state.phase = CONVERT;
          next_state.idx   = 4'h9;
          next_state.code  = 10'h200;
        end
      end
      CONVERT: begin
        if (bus.abort) begin
          next_state.phase  = IDLE;
          next_state.result = fill_partial(state.code, state.idx); // [R19]
          next_state.done   = 1'b1;
        end else if (bus.tick) begin
          c[state.idx] = i_comp_high;
          if (state.idx == 4'h0) begin
            next_state.phase  = IDLE;
            next_state.result = c;
            next_state.done   = 1'b1; // [R17]
          end else begin
            c[state.idx - 4'h1] = 1'b1;
            next_state.idx = state.idx - 4'h1;
          end
          next_state.code = c;
        end
      end
      default: next_state.phase = IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign bus.busy   = (state.phase != IDLE);
  assign bus.sample = (state.phase == ACQUIRE);
  assign bus.done   = state.done;
  assign bus.dac    = state.code;
  assign bus.result = state.result;
endmodule

// [design/adc_conversion_control.sv]
// Operation
// R1 - A rising edge on the chosen trigger source sets the conversion-status bit; an edge seen in the same cycle as a control 0 write is dropped.
// R2 - A six-bit field in the trigger register picks the trigger source.
// R3 - No timing is enforced on triggered starts; software spaces the events.
// R4 - Trigger inputs cover timers, comparators, logic cells, PWM, capture and a pin.
// R5 - Software configures clock, references, channel, enables, waits, then starts.
// R6 - Software polls the status bit or uses the completion flag, then clears it.
// R7 - Channel field picks external inputs 0 to 4 and 8 to 19.
// R8 - Codes pick fixed-reference buffer, temperature indicator and internal DAC outputs.
// R9 - Three codes pick switched inputs, cut off under op-amp tri-state override.
// R10 - Reserved channel codes connect no input to the sampler.
// R11 - Writing one to bit 1 starts; it reads one while busy, clears at end.
// R12 - Bit 0 enables the converter; clearing it turns the converter off.
// R13 - Format bit picks right or left justification with zeroed unused bits.
// R14 - Three-bit clock field picks a system-clock divider or the RC clock.
// R15 - Bit 2 picks the external negative reference pin or ground.
// R16 - Two-bit field picks supply, external pin or fixed reference as positive reference.
// R17 - On completion: clear status bit, set completion flag, load both result bytes.
// R18 - Trigger code zero disables triggering; other sources are rising-edge sensitive.
// R19 - Clearing the status bit early stops and loads the partial result.
// R20 - Trigger edges during a running conversion are ignored.
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module adc_conversion_control #(
  parameter int TRIGGER_SOURCES = 64
) (
  // Clock and reset
  input  wire logic                       i_clock,
  input  wire logic                       i_sys_rst,
  // Register port
  input  wire logic [2:0]                 i_addr,
  input  wire logic [7:0]                 i_wdata,
  input  wire logic                       i_write,
  input  wire logic                       i_read,
  output logic [7:0]                      o_rdata,
  // Trigger sources, bit n is trigger code n
  input  wire logic [TRIGGER_SOURCES-1:0] i_trigger_sources,
  // Converter core
  input  wire logic                       i_rc_tick,
  input  wire logic                       i_comp_high,
  input  wire logic [2:0]                 i_override_tristate,
  output logic                            o_converter_enable,
  output logic [1:0]                      o_positive_ref,
  output logic                            o_negative_ref,
  output logic [5:0]                      o_input_select,
  output logic                            o_input_connect,
  output logic                            o_sample,
  output logic [9:0]                      o_dac_code,
  // Completion
  output logic                            o_completion_flag
);
  import adc_ctrl_pkg::*;

  typedef struct packed {
    logic [5:0] channel;
    logic       go;
    logic       enable;
    logic       format;
    logic [2:0] clock_sel;
    logic       neg_ref;
    logic [1:0] pos_ref;
    logic [5:0] trigger_sel;
    logic [7:0] result_high;
    logic [7:0] result_low;
    logic       completion;
    logic [7:0] rdata;
    logic [5:0] div_count;
    logic       tick;
    logic       start;
    logic       abort;
    logic       connect;
  } state_t;

  state_t state;
  state_t next_state;
  logic   trigger_edge_seen;

  sar_if sar ();

  trigger_edge #(
    .SOURCES (TRIGGER_SOURCES)
  ) u_trigger (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_sources (i_trigger_sources),
    .i_select  (state.trigger_sel),
    .o_edge    (trigger_edge_seen)
  );

  sar_sequencer u_sar (
    .i_clock     (i_clock),
    .i_sys_rst   (i_sys_rst),
    .i_comp_high (i_comp_high),
    .bus         (sar.core)
  );

  // Divide ratio minus one; zero means the RC clock drives the tick
  function automatic logic [5:0] divide_last(input logic [2:0] sel);
    logic [5:0] last;
    case (sel)
      CLOCK_DIV2:  last = 6'h01;
      CLOCK_DIV4:  last = 6'h03;
      CLOCK_DIV8:  last = 6'h07;
      CLOCK_DIV16: last = 6'h0f;
      CLOCK_DIV32: last = 6'h1f;
      CLOCK_DIV64: last = 6'h3f;
      default:     last = 6'h00;
    endcase
    return last;
  endfunction

  // True when the code routes an input to the sampler
  function automatic logic channel_connects(input logic [5:0] code,
                                            input logic [2:0] tristate);
    logic ok;
    ok = 1'b0;
    if (code <= 6'h04) begin
      ok = 1'b1; // [R7]
    end else if (code >= 6'h08 && code <= 6'h13) begin
      ok = 1'b1; // [R7]
    end else if (code == 6'h3f || code == 6'h3d) begin
      ok = 1'b1; // [R8]
    end else if (code == 6'h3e || code == 6'h3c || code == 6'h3b) begin
      ok = 1'b1; // [R8]
    end else if (code == 6'h3a || code == 6'h39 || code == 6'h37) begin
      ok = 1'b1; // [R8]
    end else if (code == 6'h32) begin
      ok = !tristate[2]; // [R9]
    end else if (code == 6'h2a) begin
      ok = !tristate[1]; // [R9]
    end else if (code == 6'h21) begin
      ok = !tristate[0]; // [R9]
    end else begin
      ok = 1'b0; // [R10]
    end
    return ok;
  endfunction

  // Place the ten-bit result into the two result bytes
  function automatic logic [15:0] justify(input logic [9:0] value, input logic right);
    logic [15:0] bytes;
    if (right) begin
      bytes = {6'h00, value}; // [R13]
    end else begin
      bytes = {value, 6'h00}; // [R13]
    end
    return bytes;
  endfunction

  always_comb begin
    logic        wr0;
    logic        want_start;
    logic        want_abort;
    logic [15:0] packed_result;
    wr0           = i_write && (i_addr == OFFSET_CONTROL_0);
    want_start    = 1'b0;
    want_abort    = 1'b0;
    packed_result = justify(sar.result, state.format);
    next_state    = state;
    next_state.start = 1'b0;
    next_state.abort = 1'b0;
    next_state.rdata = 8'h00;

    // Conversion clock tick
    next_state.tick = 1'b0;
    if (divide_last(state.clock_sel) == 6'h00) begin
      next_state.tick      = i_rc_tick; // [R14]
      next_state.div_count = 6'h00;
    end else if (state.div_count >= divide_last(state.clock_sel)) begin
      next_state.tick      = 1'b1; // [R14]
      next_state.div_count = 6'h00;
    end else begin
      next_state.div_count = state.div_count + 6'h01;
    end

    // Register writes
    if (wr0) begin
      next_state.channel = i_wdata[CHANNEL_LSB +: 6];
      next_state.enable  = i_wdata[ENABLE_BIT]; // [R12]
      if (i_wdata[GO_BIT] && i_wdata[ENABLE_BIT] && !state.go) begin
        want_start = 1'b1; // [R11]
      end else if (!i_wdata[GO_BIT] && state.go) begin
        want_abort = 1'b1; // [R19]
      end else if (!i_wdata[ENABLE_BIT] && state.go) begin
        // Turning off mid-conversion terminates it like an early stop
        want_abort = 1'b1; // [R12]
      end
    end
    if (i_write && i_addr == OFFSET_CONTROL_1) begin
      next_state.format    = i_wdata[FORMAT_BIT];
      next_state.clock_sel = i_wdata[CLOCK_SEL_LSB +: 3];
      next_state.neg_ref   = i_wdata[NEG_REF_BIT];
      next_state.pos_ref   = i_wdata[POS_REF_LSB +: 2];
    end
    if (i_write && i_addr == OFFSET_TRIGGER) begin
      next_state.trigger_sel = i_wdata[5:0]; // [R2]
    end
    if (i_write && i_addr == OFFSET_STATUS && i_wdata[COMPLETION_BIT]) begin
      next_state.completion = 1'b0;
    end

    // Hardware start from the trigger; a running conversion ignores it.
    // No acquisition wait is inserted, the trigger spacing is software's job.
    if (trigger_edge_seen && state.enable && !state.go && !want_start && !wr0) begin
      want_start = 1'b1; // [R1] [R20] [R3]
    end

    if (want_start) begin
      next_state.go    = 1'b1; // [R1] [R11]
      next_state.start = 1'b1;
    end
    if (want_abort) begin
      next_state.go    = 1'b0; // [R19]
      next_state.abort = 1'b1;
    end

    // Completion; the hardware set wins over a same-cycle software clear
    if (sar.done) begin
      next_state.go          = 1'b0; // [R11] [R17]
      next_state.completion  = 1'b1; // [R17]
      next_state.result_high = packed_result[15:8]; // [R17]
      next_state.result_low  = packed_result[7:0]; // [R17]
    end

    next_state.connect = channel_connects(state.channel, i_override_tristate);

    // Register reads, answered one cycle after the strobe
    if (i_read) begin
      if (i_addr == OFFSET_CONTROL_0) begin
        next_state.rdata = {state.channel, state.go, state.enable};
      end else if (i_addr == OFFSET_CONTROL_1) begin
        next_state.rdata = {state.format, state.clock_sel, 1'b0, state.neg_ref,
                            state.pos_ref};
      end else if (i_addr == OFFSET_TRIGGER) begin
        next_state.rdata = {2'b00, state.trigger_sel};
      end else if (i_addr == OFFSET_RESULT_HIGH) begin
        next_state.rdata = state.result_high;
      end else if (i_addr == OFFSET_RESULT_LOW) begin
        next_state.rdata = state.result_low;
      end else if (i_addr == OFFSET_STATUS) begin
        next_state.rdata = {7'h00, state.completion};
      end else begin
        next_state.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state             <= '0;
      state.channel     <= CONTROL_0_RESET[CHANNEL_LSB +: 6];
      state.go          <= CONTROL_0_RESET[GO_BIT];
      state.enable      <= CONTROL_0_RESET[ENABLE_BIT];
      state.format      <= CONTROL_1_RESET[FORMAT_BIT];
      state.clock_sel   <= CONTROL_1_RESET[CLOCK_SEL_LSB +: 3];
      state.neg_ref     <= CONTROL_1_RESET[NEG_REF_BIT];
      state.pos_ref     <= CONTROL_1_RESET[POS_REF_LSB +: 2];
      state.trigger_sel <= TRIGGER_RESET[5:0];
      state.result_high <= RESULT_RESET;
      state.result_low  <= RESULT_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign sar.tick  = state.tick;
  assign sar.start = state.start;
  assign sar.abort = state.abort;

  assign o_rdata            = state.rdata;
  assign o_converter_enable = state.enable; // [R12]
  assign o_positive_ref     = state.pos_ref; // [R16]
  assign o_negative_ref     = state.neg_ref; // [R15]
  assign o_input_select     = state.channel; // [R7]
  assign o_input_connect    = state.connect; // [R10]
  assign o_sample           = sar.sample;
  assign o_dac_code         = sar.dac;
  assign o_completion_flag  = state.completion;
endmodule

// [test/adc_ctrl_checker_properties.sv]
`timescale 1ns/1ns
module adc_ctrl_checker #(
  parameter int TRIGGER_SOURCES = 64
) (
  input wire logic       i_clock,
  input wire logic       i_sys_rst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_write,
  input wire logic       i_read,
  input wire logic [7:0] o_rdata,
  input wire logic       o_converter_enable,
  input wire logic [1:0] o_positive_ref,
  input wire logic       o_negative_ref,
  input wire logic [5:0] o_input_select,
  input wire logic       o_input_connect,
  input wire logic       o_sample,
  input wire logic       o_completion_flag
);
  logic wr0;
  logic wr1;
  logic clear_flag;
  assign wr0        = i_write && (i_addr == 3'h0);
  assign wr1        = i_write && (i_addr == 3'h1);
  assign clear_flag = i_write && (i_addr == 3'h5) && i_wdata[0];

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);

  chk_read_data_idle: assert property (!$past(i_read) |-> o_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  chk_enable_write: assert property (wr0 |=> o_converter_enable == $past(i_wdata[0]))
    else $error("enable does not follow the written bit");
  chk_channel_write: assert property (wr0 |=> o_input_select == $past(i_wdata[7:2]))
    else $error("channel does not follow the written field");
  chk_pos_ref_write: assert property (wr1 |=> o_positive_ref == $past(i_wdata[1:0]))
    else $error("positive reference does not follow the written field");
  chk_neg_ref_write: assert property (wr1 |=> o_negative_ref == $past(i_wdata[2]))
    else $error("negative reference does not follow the written bit");
  chk_reserved_open: assert property ((o_input_select == 6'h05) [*2] |-> !o_input_connect)
    else $error("reserved channel code connects an input");
  chk_buffer_linked: assert property ((o_input_select == 6'h3f) [*2] |-> o_input_connect)
    else $error("fixed reference buffer channel not connected");
  chk_flag_sticky: assert property (o_completion_flag && !clear_flag |=> o_completion_flag)
    else $error("completion flag dropped without a clear");
  chk_sample_stops_off: assert property (o_sample && !o_converter_enable |=> !o_sample)
    else $error("sampling continues after the converter is turned off");
  chk_ctrl1_gap_zero: assert property (i_read && i_addr == 3'h1 |=> !o_rdata[3])
    else $error("unused control 1 bit reads one");
  chk_trigger_upper: assert property (i_read && i_addr == 3'h2 |=> o_rdata[7:6] == 2'b00)
    else $error("unused trigger bits read nonzero");

  cover property ($rose(o_completion_flag));
  cover property ($rose(o_sample));
  cover property ($rose(o_input_connect));
endmodule

bind adc_conversion_control adc_ctrl_checker #(
  .TRIGGER_SOURCES(TRIGGER_SOURCES)
) i_adc_ctrl_checker (
  .i_clock            (i_clock),
  .i_sys_rst          (i_sys_rst),
  .i_addr             (i_addr),
  .i_wdata            (i_wdata),
  .i_write            (i_write),
  .i_read             (i_read),
  .o_rdata            (o_rdata),
  .o_converter_enable (o_converter_enable),
  .o_positive_ref     (o_positive_ref),
  .o_negative_ref     (o_negative_ref),
  .o_input_select     (o_input_select),
  .o_input_connect    (o_input_connect),
  .o_sample           (o_sample),
  .o_completion_flag  (o_completion_flag)
);

// [test/analog_model.sv]
`timescale 1ns/1ns
module analog_model #(
  parameter int RC_PERIOD = 5
) (
  input  wire logic       i_clock,
  input  wire logic [9:0] i_dac_code,
  input  wire logic [9:0] i_level,
  output logic            o_comp_high,
  output logic            o_rc_tick
);
  int count = 0;
  initial o_rc_tick = 1'b0;
  // Held input against the trial code, as the converter core decides it
  assign o_comp_high = (i_level >= i_dac_code);
  // RC oscillator runs free; a short period keeps RC conversions quick
  always @(posedge i_clock) begin
    count     <= (count == RC_PERIOD - 1) ? 0 : count + 1;
    o_rc_tick <= (count == RC_PERIOD - 1);
  end
endmodule

// [test/tb.sv]
`timescale 1ns/1ns
module tb;
  import adc_ctrl_pkg::*;
  localparam logic [5:0] CODES [21] = '{6'h00, 6'h04, 6'h05, 6'h08, 6'h13, 6'h14, 6'h3f,
    6'h3d, 6'h3e, 6'h3c, 6'h3b, 6'h3a, 6'h39, 6'h37, 6'h38, 6'h32, 6'h2a, 6'h21, 6'h21,
    6'h2a, 6'h32};
  localparam logic [20:0] LINKED = 21'b000111011111111011011;
  localparam logic [5:0]  SELS [5] = '{6'h01, 6'h05, 6'h0a, 6'h12, 6'h29};
  logic        i_clock             = 1'b0;
  logic        i_sys_rst           = 1'b1;
  logic [2:0]  i_addr              = 3'h0;
  logic [7:0]  i_wdata             = 8'h00;
  logic        i_write             = 1'b0;
  logic        i_read              = 1'b0;
  logic [63:0] i_trigger_sources   = 64'h0;
  logic [2:0]  i_override_tristate = 3'h0;
  logic [9:0]  level               = 10'h2b5;
  logic [7:0]  rd;
  logic [7:0]  o_rdata;
  logic [1:0]  o_positive_ref;
  logic [5:0]  o_input_select;
  logic [9:0]  o_dac_code;
  logic        rc_tick;
  logic        comp_high;
  logic        o_converter_enable;
  logic        o_negative_ref;
  logic        o_input_connect;
  logic        o_sample;
  logic        o_completion_flag;
  int          fail_count  = 0;
  int          checks_done = 0;

  always #2 i_clock = ~i_clock;

  adc_conversion_control i_adc_conversion_control (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
    .i_trigger_sources(i_trigger_sources), .i_rc_tick(rc_tick), .i_comp_high(comp_high),
    .i_override_tristate(i_override_tristate), .o_converter_enable(o_converter_enable),
    .o_positive_ref(o_positive_ref), .o_negative_ref(o_negative_ref),
    .o_input_select(o_input_select), .o_input_connect(o_input_connect),
    .o_sample(o_sample), .o_dac_code(o_dac_code), .o_completion_flag(o_completion_flag));

  analog_model i_analog_model (
    .i_clock(i_clock), .i_dac_code(o_dac_code), .i_level(level),
    .o_comp_high(comp_high), .o_rc_tick(rc_tick));

  task automatic summarize();
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_write <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_read <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    rd_reg(OFFSET_CONTROL_0, rd);
    while (rd[GO_BIT] !== 1'b0) begin
      n++;
      if (n > 3000) begin
        fail_count++;
        summarize();
      end
      rd_reg(OFFSET_CONTROL_0, rd);
    end
  endtask

  task automatic check_result(input logic fmt, input logic [9:0] v);
    check("flag", 16'h1, {15'h0, o_completion_flag});
    rd_reg(OFFSET_RESULT_HIGH, rd);
    check("result high", fmt ? {14'h0, v[9:8]} : {8'h0, v[9:2]}, {8'h0, rd});
    rd_reg(OFFSET_RESULT_LOW, rd);
    check("result low", fmt ? {8'h0, v[7:0]} : {8'h0, v[1:0], 6'h0}, {8'h0, rd});
    rd_reg(OFFSET_STATUS, rd);
    check("status", 16'h1, {8'h0, rd});
    wr_reg(OFFSET_STATUS, 8'h01);
    #1;
    check("flag cleared", 16'h0, {15'h0, o_completion_flag});
  endtask

  initial begin
    repeat (16) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd_reg(3'(a), rd);
      check("reset value", 16'h0, {8'h0, rd});
    end
    wr_reg(OFFSET_RESULT_HIGH, 8'haa);
    rd_reg(OFFSET_RESULT_HIGH, rd);
    check("result read only", 16'h0, {8'h0, rd});
    wr_reg(OFFSET_CONTROL_1, 8'h8f);
    rd_reg(OFFSET_CONTROL_1, rd);
    check("control 1", 16'h87, {8'h0, rd});
    check("refs", 16'h7, {13'h0, o_negative_ref, o_positive_ref});
    wr_reg(OFFSET_TRIGGER, 8'hff);
    rd_reg(OFFSET_TRIGGER, rd);
    check("trigger select", 16'h3f, {8'h0, rd});
    wr_reg(OFFSET_TRIGGER, 8'h00);
    for (int k = 0; k < 21; k++) begin
      @(posedge i_clock);
      i_override_tristate <= (k < 18) ? 3'h0 : 3'(1 << (k - 18));
      wr_reg(OFFSET_CONTROL_0, {CODES[k], 2'b00});
      repeat (3) @(posedge i_clock);
      #1;
      check("input select", {10'h0, CODES[k]}, {10'h0, o_input_select});
      check("input connect", {15'h0, LINKED[k]}, {15'h0, o_input_connect});
    end
    check("enable off", 16'h0, {15'h0, o_converter_enable});
    for (int c = 0; c < 8; c++) begin
      level = 10'h3ff - 10'(c * 146);
      wr_reg(OFFSET_CONTROL_1, {c[0], c[2:0], 4'h0});
      wr_reg(OFFSET_CONTROL_0, 8'h01);
      wr_reg(OFFSET_CONTROL_0, 8'h03);
      rd_reg(OFFSET_CONTROL_0, rd);
      check("busy status", 16'h3, {8'h0, rd});
      wait_idle();
      check_result(c[0], level);
    end
    level = 10'h3ff;
    wr_reg(OFFSET_CONTROL_1, 8'he0);
    wr_reg(OFFSET_CONTROL_0, 8'h03);
    repeat (300) @(posedge i_clock);
    #1;
    check("trial code", 16'h7, {13'h0, o_dac_code[9:7]});
    check("sampling over", 16'h0, {15'h0, o_sample});
    wr_reg(OFFSET_CONTROL_0, 8'h01);
    rd_reg(OFFSET_CONTROL_0, rd);
    check("aborted status", 16'h1, {8'h0, rd});
    check_result(1'b1, 10'h3ff);
    level = 10'h1c6;
    wr_reg(OFFSET_CONTROL_1, 8'h80);
    for (int s = 0; s < 5; s++) begin
      wr_reg(OFFSET_TRIGGER, {2'b00, SELS[s]});
      @(posedge i_clock);
      i_trigger_sources[SELS[s]] <= 1'b1;
      repeat (4) @(posedge i_clock);
      i_trigger_sources[SELS[s]] <= 1'b0;
      repeat (2) @(posedge i_clock);
      i_trigger_sources[SELS[s]] <= 1'b1;
      rd_reg(OFFSET_CONTROL_0, rd);
      check("triggered status", 16'h3, {8'h0, rd});
      wait_idle();
      check_result(1'b1, level);
      @(posedge i_clock);
      i_trigger_sources <= 64'h0;
      repeat (30) @(posedge i_clock);
      #1;
      check("no second start", 16'h0, {15'h0, o_completion_flag});
    end
    wr_reg(OFFSET_TRIGGER, 8'h00);
    @(posedge i_clock);
    i_trigger_sources <= '1;
    repeat (30) @(posedge i_clock);
    rd_reg(OFFSET_CONTROL_0, rd);
    check("trigger off status", 16'h1, {8'h0, rd});
    check("trigger off flag", 16'h0, {15'h0, o_completion_flag});
    summarize();
  end
endmodule
